// [include/eppi_regs.svh]
`ifndef EPPI_REGS_SVH
`define EPPI_REGS_SVH

// ****************************************************************
// Pin widths and memory depth
// ****************************************************************
`define EPPI_ADDR_W 13
`define EPPI_DATA_W 8
`define EPPI_DEPTH 8192

// ****************************************************************
// Timing figures in nanoseconds
// ****************************************************************
`define EPPI_CLK_PERIOD_NS 100
`define EPPI_T_PW_NOM_NS 100000
`define EPPI_T_PW_MIN_NS 95000
`define EPPI_T_PW_MAX_NS 105000
`define EPPI_T_SETUP_NS 2000
`define EPPI_T_HOLD_NS 2000
`define EPPI_T_FLOAT_NS 130

// ****************************************************************
// Loop limits, field positions and reset values
// ****************************************************************
`define EPPI_MAX_EXTRA_PULSES 10
`define EPPI_ID_SEL_BIT 0
`define EPPI_PINS_RESET_ADDR 13'h0000

`endif

// [include/eppi_pkg.sv]
`include "eppi_regs.svh"

package eppi_pkg;

    typedef enum logic [1:0] {
        EPPI_CS_LOW = 2'h0,
        EPPI_CS_HIGH = 2'h1,
        EPPI_CS_VPP = 2'h2
    } eppi_cs_type;

    typedef enum logic [1:0] {
        EPPI_VCC_OFF = 2'h0,
        EPPI_VCC_V50 = 2'h1,
        EPPI_VCC_V65 = 2'h2
    } eppi_vcc_type;

    typedef enum logic [9:0] {
        EPPI_ST_IDLE = 10'h001,
        EPPI_ST_PWR_UP = 10'h002,
        EPPI_ST_SETUP = 10'h004,
        EPPI_ST_PULSE = 10'h008,
        EPPI_ST_HOLD = 10'h010,
        EPPI_ST_VERIFY = 10'h020,
        EPPI_ST_FIN_DROP = 10'h040,
        EPPI_ST_PWR_DN = 10'h080,
        EPPI_ST_ID_READ = 10'h100
    } eppi_state_type;

    typedef struct packed {
        logic [`EPPI_ADDR_W-1:0] addr;
        logic [`EPPI_DATA_W-1:0] data;
        logic data_oe_n;
        eppi_cs_type cs_level;
        eppi_vcc_type vcc_level;
        logic id_mode_high_voltage_line;
    } eppi_pins_type;

endpackage : eppi_pkg

// [design/eppi_src_mem.sv]
`timescale 1ns/1ps

module eppi_src_mem #(
    parameter int ADDR_W = 13,
    parameter int DATA_W = 8
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic wr_en_in,
    input wire logic [ADDR_W-1:0] wr_addr_in,
    input wire logic [DATA_W-1:0] wr_data_in,
    input wire logic [ADDR_W-1:0] rd_addr_in,
    output logic [DATA_W-1:0] rd_data_out
);

    logic [DATA_W-1:0] mem_q [0:(1<<ADDR_W)-1];

    // The array has no reset, so the image must be loaded before a run.
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_q[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_out <= '0;
        end else begin
            rd_data_out <= mem_q[rd_addr_in];
        end
    end

endmodule : eppi_src_mem

// [design/eppi_programmer.sv]
`timescale 1ns/1ps

`include "eppi_regs.svh"

module eppi_programmer
    import eppi_pkg::*;
#(
    parameter int DEPTH = `EPPI_DEPTH
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic prog_start_in,
    input wire logic id_start_in,
    input wire logic id_sel_in,
    input wire logic load_en_in,
    input wire logic [`EPPI_ADDR_W-1:0] load_addr_in,
    input wire logic [`EPPI_DATA_W-1:0] load_data_in,
    input wire logic [`EPPI_DATA_W-1:0] data_output_lines_in,
    output eppi_pins_type pins_out,
    output logic busy_out,
    output logic done_out,
    output logic pass_out,
    output logic fail_out,
    output logic [`EPPI_ADDR_W-1:0] fail_addr_out,
    output logic [`EPPI_DATA_W-1:0] id_code_out
);

    // ****************************************************************
    // Timing counts
    // ****************************************************************
    localparam int CLK_NS = `EPPI_CLK_PERIOD_NS;
    localparam int PW_CYC = `EPPI_T_PW_NOM_NS / CLK_NS;
    localparam int PW_MIN_CYC = (`EPPI_T_PW_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int PW_MAX_CYC = `EPPI_T_PW_MAX_NS / CLK_NS;
    localparam int SETUP_CYC = (`EPPI_T_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC = (`EPPI_T_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int FLOAT_CYC = (`EPPI_T_FLOAT_NS + CLK_NS - 1) / CLK_NS;
    localparam int FAIL_WAIT = SETUP_CYC + 2;
    localparam logic [10:0] PW_END = 11'(PW_CYC - 1);
    localparam logic [10:0] SETUP_END = 11'(SETUP_CYC - 1);
    localparam logic [10:0] HOLD_END = 11'(HOLD_CYC - 1);
    localparam logic [10:0] FLOAT_END = 11'(FLOAT_CYC - 1);
    localparam logic [10:0] DRIVE_END = 11'(FLOAT_CYC + SETUP_CYC - 1);
    localparam logic [3:0] MAX_EXTRA = 4'(`EPPI_MAX_EXTRA_PULSES);
    localparam logic [`EPPI_ADDR_W-1:0] LAST_ADDR = `EPPI_ADDR_W'(DEPTH - 1);

    if (DEPTH < 2 || DEPTH > (1 << `EPPI_ADDR_W) || PW_CYC > 2047) begin : g_check
        $error("eppi_programmer: DEPTH or timing out of range");
    end

    // ****************************************************************
    // Reset release and data line synchroniser
    // ****************************************************************
    logic rst_s1_q, rst_n_sync;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_s1_q <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_sync <= rst_s1_q;
        end
    end

    logic [`EPPI_DATA_W-1:0] din_s1_q, din_s2_q, din_s3_q, din_q, din_d;
    always_comb begin
        din_d = (din_s2_q == din_s3_q) ? din_s3_q : din_q;
    end
    always_ff @(posedge clk_in or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            din_s1_q <= '1;
            din_s2_q <= '1;
            din_s3_q <= '1;
            din_q <= '1;
        end else begin
            din_s1_q <= data_output_lines_in;
            din_s2_q <= din_s1_q;
            din_s3_q <= din_s2_q;
            din_q <= din_d;
        end
    end

    // ****************************************************************
    // Source image
    // ****************************************************************
    logic [`EPPI_DATA_W-1:0] src_data;
    eppi_src_mem #(
        .ADDR_W(`EPPI_ADDR_W),
        .DATA_W(`EPPI_DATA_W)
    ) u_src_mem (
        .clk_in(clk_in),
        .rst_n_in(rst_n_sync),
        .wr_en_in(load_en_in),
        .wr_addr_in(load_addr_in),
        .wr_data_in(load_data_in),
        .rd_addr_in(pins_out.addr),
        .rd_data_out(src_data)
    );

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    eppi_state_type st_q, st_d;
    eppi_pins_type pins_d;
    logic [10:0] tmr_q, tmr_d;
    logic [3:0] ext_q, ext_d;
    logic pass1_q, pass1_d, final_q, final_d;
    logic busy_d, done_d, pass_d, fail_d;
    logic [`EPPI_ADDR_W-1:0] fail_addr_d;
    logic [`EPPI_DATA_W-1:0] id_code_d;
    logic vfy_now, miss, last;

    assign vfy_now = (st_q == EPPI_ST_VERIFY) && (tmr_q == SETUP_END);
    assign miss = (din_q != src_data);
    assign last = (pins_out.addr == LAST_ADDR);

    always_comb begin
        st_d = st_q;
        pins_d = pins_out;
        tmr_d = tmr_q + 11'h001;
        ext_d = ext_q;
        pass1_d = pass1_q;
        final_d = final_q;
        done_d = 1'b0;
        pass_d = pass_out;
        fail_d = fail_out;
        fail_addr_d = fail_addr_out;
        id_code_d = id_code_out;
        unique case (st_q)
            EPPI_ST_IDLE: begin
                tmr_d = 11'h000;
                if (prog_start_in) begin
                    pins_d.addr = '0;
                    pins_d.vcc_level = EPPI_VCC_V65;
                    pass1_d = 1'b1;
                    final_d = 1'b0;
                    ext_d = 4'h0;
                    pass_d = 1'b0;
                    fail_d = 1'b0;
                    st_d = EPPI_ST_PWR_UP;
                end else if (id_start_in) begin
                    pins_d.addr = '0;
                    pins_d.addr[`EPPI_ID_SEL_BIT] = id_sel_in;
                    pins_d.vcc_level = EPPI_VCC_V50;
                    pins_d.cs_level = EPPI_CS_LOW;
                    pins_d.id_mode_high_voltage_line = 1'b1;
                    st_d = EPPI_ST_ID_READ;
                end
            end
            EPPI_ST_PWR_UP: begin
                if (tmr_q == SETUP_END) begin
                    pins_d.cs_level = EPPI_CS_HIGH;
                    tmr_d = 11'h000;
                    st_d = EPPI_ST_SETUP;
                end
            end
            EPPI_ST_SETUP: begin
                // Waiting out the output float time avoids driving against the part.
                if (tmr_q >= FLOAT_END) begin
                    pins_d.data_oe_n = 1'b0;
                    pins_d.data = src_data;
                end
                if (tmr_q == DRIVE_END) begin
                    pins_d.cs_level = EPPI_CS_VPP;
                    tmr_d = 11'h000;
                    st_d = EPPI_ST_PULSE;
                end
            end
            EPPI_ST_PULSE: begin
                if (tmr_q == PW_END) begin
                    pins_d.cs_level = EPPI_CS_HIGH;
                    tmr_d = 11'h000;
                    st_d = EPPI_ST_HOLD;
                end
            end
            EPPI_ST_HOLD: begin
                if (tmr_q == HOLD_END) begin
                    pins_d.data_oe_n = 1'b1;
                    tmr_d = 11'h000;
                    if (pass1_q && !last) begin
                        pins_d.addr = pins_out.addr + `EPPI_ADDR_W'(1);
                        st_d = EPPI_ST_SETUP;
                    end else begin
                        if (pass1_q) begin
                            pins_d.addr = '0;
                        end
                        pass1_d = 1'b0;
                        pins_d.cs_level = EPPI_CS_LOW;
                        st_d = EPPI_ST_VERIFY;
                    end
                end
            end
            EPPI_ST_VERIFY: begin
                if (vfy_now) begin
                    tmr_d = 11'h000;
                    if (!miss) begin
                        ext_d = 4'h0;
                        if (!last) begin
                            pins_d.addr = pins_out.addr + `EPPI_ADDR_W'(1);
                        end else if (final_q) begin
                            pass_d = 1'b1;
                            pins_d.cs_level = EPPI_CS_HIGH;
                            st_d = EPPI_ST_PWR_DN;
                        end else begin
                            pins_d.cs_level = EPPI_CS_HIGH;
                            st_d = EPPI_ST_FIN_DROP;
                        end
                    end else if (final_q || ext_q == MAX_EXTRA) begin
                        fail_d = 1'b1;
                        fail_addr_d = pins_out.addr;
                        pins_d.cs_level = EPPI_CS_HIGH;
                        st_d = EPPI_ST_PWR_DN;
                    end else begin
                        ext_d = ext_q + 4'h1;
                        pins_d.cs_level = EPPI_CS_HIGH;
                        st_d = EPPI_ST_SETUP;
                    end
                end
            end
            EPPI_ST_FIN_DROP: begin
                if (tmr_q == SETUP_END) begin
                    pins_d.vcc_level = EPPI_VCC_V50;
                    pins_d.cs_level = EPPI_CS_LOW;
                    pins_d.addr = '0;
                    final_d = 1'b1;
                    tmr_d = 11'h000;
                    st_d = EPPI_ST_VERIFY;
                end
            end
            EPPI_ST_ID_READ: begin
                if (tmr_q == SETUP_END) begin
                    id_code_d = din_q;
                    pins_d.id_mode_high_voltage_line = 1'b0;
                    pins_d.cs_level = EPPI_CS_HIGH;
                    tmr_d = 11'h000;
                    st_d = EPPI_ST_PWR_DN;
                end
            end
            EPPI_ST_PWR_DN: begin
                if (tmr_q == SETUP_END) begin
                    pins_d.cs_level = EPPI_CS_LOW;
                    pins_d.vcc_level = EPPI_VCC_OFF;
                    done_d = 1'b1;
                    st_d = EPPI_ST_IDLE;
                end
            end
            default: begin
                st_d = EPPI_ST_IDLE;
            end
        endcase
        busy_d = (st_d != EPPI_ST_IDLE);
    end

    always_ff @(posedge clk_in or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            st_q <= EPPI_ST_IDLE;
            pins_out <= '{addr: `EPPI_PINS_RESET_ADDR, data: '1, data_oe_n: 1'b1,
                          cs_level: EPPI_CS_LOW, vcc_level: EPPI_VCC_OFF,
                          id_mode_high_voltage_line: 1'b0};
            tmr_q <= 11'h000;
            ext_q <= 4'h0;
            pass1_q <= 1'b0;
            final_q <= 1'b0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            pass_out <= 1'b0;
            fail_out <= 1'b0;
            fail_addr_out <= '0;
            id_code_out <= '0;
        end else begin
            st_q <= st_d;
            pins_out <= pins_d;
            tmr_q <= tmr_d;
            ext_q <= ext_d;
            pass1_q <= pass1_d;
            final_q <= final_d;
            busy_out <= busy_d;
            done_out <= done_d;
            pass_out <= pass_d;
            fail_out <= fail_d;
            fail_addr_out <= fail_addr_d;
            id_code_out <= id_code_d;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [10:0] pw_cnt_q, pw_cnt_d;
    always_comb begin
        pw_cnt_d = (pins_out.cs_level == EPPI_CS_VPP) ? pw_cnt_q + 11'h001 : 11'h000;
    end
    always_ff @(posedge clk_in or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            pw_cnt_q <= 11'h000;
        end else begin
            pw_cnt_q <= pw_cnt_d;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_sync);

    sequence seq_pulse_end;
        $fell(pins_out.cs_level == EPPI_CS_VPP);
    endsequence
    sequence seq_last_miss;
        vfy_now && miss && !final_q && (ext_q == MAX_EXTRA);
    endsequence

    AST_PULSE_WIDTH: assert property (seq_pulse_end |->
        (pw_cnt_q >= PW_MIN_CYC && pw_cnt_q <= PW_MAX_CYC))
        else $error("program pulse width out of range");
    AST_PROG_LEVELS: assert property ((pins_out.cs_level == EPPI_CS_VPP) |->
        (pins_out.vcc_level == EPPI_VCC_V65 && !pins_out.data_oe_n))
        else $error("pulse without program supply or data");
    AST_FIRST_PASS: assert property ((pass1_q && st_q == EPPI_ST_HOLD) |->
        (ext_q == 4'h0 && pins_out.cs_level != EPPI_CS_LOW))
        else $error("read-back during first pass");
    AST_EXTRA_LIMIT: assert property (ext_q <= MAX_EXTRA)
        else $error("too many extra pulses");
    AST_FAIL_LIMIT: assert property (seq_last_miss |=>
        fail_out ##[1:FAIL_WAIT] done_out)
        else $error("exhausted byte not failed");
    AST_NEXT_ADDR: assert property ((vfy_now && !miss && !last) |=>
        (pins_out.addr == $past(pins_out.addr) + `EPPI_ADDR_W'(1)))
        else $error("address did not advance after verify");
    AST_FINAL_LEVELS: assert property ((final_q && st_q == EPPI_ST_VERIFY) |->
        (pins_out.vcc_level == EPPI_VCC_V50 && pins_out.cs_level == EPPI_CS_LOW))
        else $error("final read not at normal levels");
    AST_SUPPLY_ORDER: assert property ($changed(pins_out.vcc_level) |->
        ($past(pins_out.cs_level) != EPPI_CS_VPP))
        else $error("supply changed during program voltage");
    AST_ID_LINES: assert property (pins_out.id_mode_high_voltage_line |->
        (pins_out.cs_level == EPPI_CS_LOW && pins_out.addr[`EPPI_ADDR_W-1:1] == '0))
        else $error("identification lines wrong");
    AST_RESULT: assert property ($rose(fail_out) |->
        (!pass_out && fail_addr_out == pins_out.addr && st_q == EPPI_ST_PWR_DN))
        else $error("failure report inconsistent");

endmodule : eppi_programmer

// [testbench/eppi_dev_model.sv]
`timescale 1ns/1ps

// ****************************************************************
// Behavioural memory device on the far side of the programmer.
// ****************************************************************
module eppi_dev_model
    import eppi_pkg::*;
#(
    parameter int DEPTH = 4,
    parameter logic [7:0] MFR_CODE = 8'h3a, // Arbitrary value.
    parameter logic [7:0] DEV_CODE = 8'h71, // Arbitrary value.
    parameter int WEAK_ADDR = 0,
    parameter int WEAK_PULSES = 4,
    parameter int STUCK_ADDR = 2,
    parameter int CORRUPT_ADDR = 3
) (
    input wire logic clk_in,
    input wire eppi_pins_type pins_in,
    input wire logic erase_in,
    input wire logic weak_en_in,
    input wire logic stuck_en_in,
    input wire logic corrupt_en_in,
    input wire logic slow_in,
    output logic [7:0] data_out,
    output logic [7:0] err_cnt_out
);
    logic [7:0] mem_q [DEPTH];
    int pulse_cnt_q [DEPTH];
    int width_q = 0;
    int need;
    int a;
    logic [7:0] pulse_data_q;
    logic [7:0] last_q = 8'h00;
    logic [7:0] pipe_q [8];
    logic drive;
    logic [7:0] value;

    initial begin
        err_cnt_out = 8'h00;
        for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] = 8'hff;
            pulse_cnt_q[i] = 0;
        end
    end

    always_comb begin
        a = int'(pins_in.addr);
        need = (weak_en_in && a == WEAK_ADDR) ? WEAK_PULSES : 1;
        drive = pins_in.cs_level == EPPI_CS_LOW && pins_in.vcc_level != EPPI_VCC_OFF &&
            pins_in.data_oe_n;
        if (pins_in.id_mode_high_voltage_line) begin
            value = pins_in.addr[0] ? DEV_CODE : MFR_CODE;
        end else if (a < DEPTH) begin
            value = mem_q[a];
        end else begin
            value = 8'hff;
        end
        if (corrupt_en_in && a == CORRUPT_ADDR && pins_in.vcc_level == EPPI_VCC_V50) begin
            value = value ^ 8'h01;
        end
    end

    // A released line shows the inverse of its last value, never a stale match.
    assign data_out = !drive ? ~last_q : (slow_in ? pipe_q[7] : value);

    always @(posedge clk_in) begin
        pipe_q[0] <= value;
        for (int i = 1; i < 8; i++) begin
            pipe_q[i] <= pipe_q[i-1];
        end
        if (drive) begin
            last_q <= data_out;
        end
        if (erase_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= 8'hff;
                pulse_cnt_q[i] <= 0;
            end
        end
        if (pins_in.cs_level == EPPI_CS_VPP) begin
            width_q <= width_q + 1;
            pulse_data_q <= pins_in.data;
            if (pins_in.vcc_level != EPPI_VCC_V65 || pins_in.data_oe_n) begin
                err_cnt_out <= err_cnt_out + 8'h01;
            end
        end else if (width_q > 0) begin
            width_q <= 0;
            if (width_q < 950 || width_q > 1050) begin
                err_cnt_out <= err_cnt_out + 8'h01;
            end
            if (a < DEPTH) begin
                pulse_cnt_q[a] <= pulse_cnt_q[a] + 1;
                if (pulse_cnt_q[a] >= 11) begin
                    err_cnt_out <= err_cnt_out + 8'h01;
                end
                if (pulse_cnt_q[a] + 1 >= need) begin
                    // Programming only clears bits; a stuck cell keeps bit zero set.
                    mem_q[a] <= mem_q[a] & (pulse_data_q |
                        ((stuck_en_in && a == STUCK_ADDR) ? 8'h01 : 8'h00));
                end
            end
        end
        if (pins_in.vcc_level == EPPI_VCC_OFF && pins_in.cs_level != EPPI_CS_LOW) begin
            err_cnt_out <= err_cnt_out + 8'h01;
        end
        if (pins_in.id_mode_high_voltage_line &&
            (pins_in.cs_level != EPPI_CS_LOW || pins_in.addr[12:1] != 12'h000)) begin
            err_cnt_out <= err_cnt_out + 8'h01;
        end
    end
endmodule : eppi_dev_model

// [testbench/eprom_program_and_identify_tb_top.sv]
`timescale 1ns/1ps

module eprom_program_and_identify_tb_top;
    import eppi_pkg::*;
    localparam int DEPTH = 4;
    localparam logic [7:0] MFR = 8'h3a; // Arbitrary value.
    localparam logic [7:0] DEV = 8'h71; // Arbitrary value.
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic prog_start_in = 1'b0;
    logic id_start_in = 1'b0;
    logic id_sel_in = 1'b0;
    logic load_en_in = 1'b0;
    logic [12:0] load_addr_in = 13'h0000;
    logic [7:0] load_data_in = 8'h00;
    logic erase = 1'b0;
    logic weak_en = 1'b0;
    logic stuck_en = 1'b0;
    logic corrupt_en = 1'b0;
    logic slow = 1'b0;
    logic [7:0] dev_data;
    logic [7:0] dev_err;
    eppi_pins_type pins;
    logic busy, done, pass, fail;
    logic [12:0] fail_addr;
    logic [7:0] id_code;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [7:0] image [DEPTH] = '{8'h5a, 8'hff, 8'ha4, 8'h3c};

    eppi_programmer #(.DEPTH(DEPTH)) i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .prog_start_in(prog_start_in), .id_start_in(id_start_in), .id_sel_in(id_sel_in),
        .load_en_in(load_en_in), .load_addr_in(load_addr_in), .load_data_in(load_data_in),
        .data_output_lines_in(dev_data), .pins_out(pins), .busy_out(busy), .done_out(done),
        .pass_out(pass), .fail_out(fail), .fail_addr_out(fail_addr), .id_code_out(id_code));

    eppi_dev_model #(.DEPTH(DEPTH), .MFR_CODE(MFR), .DEV_CODE(DEV)) i_dev (.clk_in(clk_in),
        .pins_in(pins), .erase_in(erase), .weak_en_in(weak_en), .stuck_en_in(stuck_en),
        .corrupt_en_in(corrupt_en), .slow_in(slow), .data_out(dev_data),
        .err_cnt_out(dev_err));

    // ****************************************************************
    // Clock, timeout and shared tasks
    // ****************************************************************
    initial begin
        forever #50 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_errors = n_errors + 1;
            final_report();
        end
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic step();
        @(posedge clk_in);
        #1;
    endtask : step

    // Waits for the completion pulse and checks that it lasts one cycle.
    task automatic wait_done();
        int i;
        for (i = 0; i < 20000; i++) begin
            @(posedge clk_in);
            #2;
            if (done === 1'b1) begin
                break;
            end
        end
        check("done_seen", 16'(done), 16'h0001);
        step();
        check("done_pulse", 16'(done), 16'h0000);
    endtask : wait_done

    task automatic run_prog(input logic w, input logic s, input logic c);
        weak_en = w;
        stuck_en = s;
        corrupt_en = c;
        erase = 1'b1;
        step();
        erase = 1'b0;
        prog_start_in = 1'b1;
        step();
        prog_start_in = 1'b0;
        #2;
        check("busy", 16'(busy), 16'h0001);
        wait_done();
        check("dev_err", 16'(dev_err), 16'h0000);
    endtask : run_prog

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        check("cs", 16'(pins.cs_level), 16'(EPPI_CS_LOW));
        check("vcc", 16'(pins.vcc_level), 16'(EPPI_VCC_OFF));
        check("oe_n", 16'(pins.data_oe_n), 16'h0001);
        check("busy", 16'(busy), 16'h0000);
    endtask : t_reset

    task automatic t_id(input logic sel, input logic sl);
        slow = sl;
        id_sel_in = sel;
        id_start_in = 1'b1;
        step();
        id_start_in = 1'b0;
        repeat (10) step();
        check("id_line", 16'(pins.id_mode_high_voltage_line), 16'h0001);
        check("id_addr", 16'(pins.addr), 16'(sel));
        check("id_cs", 16'(pins.cs_level), 16'(EPPI_CS_LOW));
        wait_done();
        check("id_code", 16'(id_code), 16'(sel ? DEV : MFR));
        slow = 1'b0;
    endtask : t_id

    task automatic t_prog_ok();
        run_prog(1'b0, 1'b0, 1'b0);
        check("pass", 16'(pass), 16'h0001);
        check("fail", 16'(fail), 16'h0000);
        for (int a = 0; a < DEPTH; a++) begin
            check("mem", 16'(i_dev.mem_q[a]), 16'(image[a]));
            check("pulses", 16'(i_dev.pulse_cnt_q[a]), 16'h0001);
        end
    endtask : t_prog_ok

    task automatic t_prog_stuck();
        run_prog(1'b0, 1'b1, 1'b0);
        check("fail", 16'(fail), 16'h0001);
        check("pass", 16'(pass), 16'h0000);
        check("fail_addr", 16'(fail_addr), 16'h0002);
        check("pulses2", 16'(i_dev.pulse_cnt_q[2]), 16'h000b);
        check("pulses3", 16'(i_dev.pulse_cnt_q[3]), 16'h0001);
    endtask : t_prog_stuck

    task automatic t_prog_weak();
        run_prog(1'b1, 1'b0, 1'b0);
        check("pass", 16'(pass), 16'h0001);
        check("fail", 16'(fail), 16'h0000);
        check("pulses0", 16'(i_dev.pulse_cnt_q[0]), 16'h0004);
        check("pulses3", 16'(i_dev.pulse_cnt_q[3]), 16'h0001);
        check("mem0", 16'(i_dev.mem_q[0]), 16'(image[0]));
    endtask : t_prog_weak

    task automatic t_prog_final();
        run_prog(1'b0, 1'b0, 1'b1);
        check("fail", 16'(fail), 16'h0001);
        check("pass", 16'(pass), 16'h0000);
        check("fail_addr", 16'(fail_addr), 16'h0003);
        check("pulses3", 16'(i_dev.pulse_cnt_q[3]), 16'h0001);
    endtask : t_prog_final

    initial begin
        repeat (12) @(posedge clk_in);
        #1;
        rst_n_in = 1'b1;
        repeat (3) step();
        t_reset();
        for (int a = 0; a < DEPTH; a++) begin
            load_en_in = 1'b1;
            load_addr_in = 13'(a);
            load_data_in = image[a];
            step();
        end
        load_en_in = 1'b0;
        step();
        t_id(1'b0, 1'b0);
        t_id(1'b1, 1'b1);
        t_prog_ok();
        t_prog_stuck();
        t_prog_weak();
        t_prog_final();
        final_report();
    end
endmodule : eprom_program_and_identify_tb_top
